// ==== inc/hcec_defines.vh ====
// constants of the counter parameter error checker
`ifndef HCEC_DEFINES_VH
`define HCEC_DEFINES_VH
// ----------------------------------------------------------------
// register map (word index on the address port)
// ----------------------------------------------------------------
`define HCEC_AW 7
`define HCEC_NCH 4
`define HCEC_CH_STRIDE 28
`define HCEC_OFF_CTRL 0
`define HCEC_OFF_SCALE 1
`define HCEC_OFF_CYC 2
`define HCEC_OFF_CMP_LO 3
`define HCEC_OFF_CMP_HI 4
`define HCEC_OFF_LIMIT 5
`define HCEC_OFF_IRQN 6
`define HCEC_OFF_CHERR 7
`define HCEC_ADDR_LAST 7'h70
`define HCEC_ADDR_ISTAT 7'h71
`define HCEC_ADDR_IMASK 7'h72
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define HCEC_CTRL_CLR_BIT 1
`define HCEC_LAST_VLD_BIT 16
`define HCEC_RST_CYC 32'h0000_0002
`define HCEC_RST_ZERO 32'h0000_0000
// ----------------------------------------------------------------
// legal ranges
// ----------------------------------------------------------------
`define HCEC_SCALE_MAX 32'h0000_7FFF
`define HCEC_CYC_MIN 32'h0000_0002
`define HCEC_CYC_MAX 32'h0000_003C
`define HCEC_CMP_MIN 64'hFFFF_FFFD_ABF4_1C01
`define HCEC_CMP_MAX 64'h0000_0000_3B9A_C9FF
`define HCEC_LIM_MIN 32'hFFFC_F2C0
`define HCEC_LIM_MAX 32'h0003_0D40
`define HCEC_IRQN_MAX 32'h0000_001F
// ----------------------------------------------------------------
// error codes: prefix, channel digit, type digit
// ----------------------------------------------------------------
`define HCEC_ERR_PREFIX 8'hA0
`define HCEC_TYP_NONE 4'h0
`define HCEC_TYP_OVF 4'h1
`define HCEC_TYP_SCALE 4'h2
`define HCEC_TYP_CYC 4'h3
`define HCEC_TYP_CMP 4'h4
`define HCEC_TYP_LIM 4'h5
`define HCEC_TYP_IRQN 4'h6
`endif

// ==== rtl/hcec_checker.v ====
// parameter checker and error code reporter for four counter channels
`timescale 1ns/100ps
`include "hcec_defines.vh"

module hcec_checker (
    input wire clock,
    input wire nrst,
    input wire [6:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire [3:0] acc_ovf,
    output reg [3:0] acc_clr,
    output reg [15:0] err_code,
    output reg err_valid,
    output reg irq
);

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
reg [31:0] ctrl_r [0:3];
reg [31:0] scale_r [0:3];
reg [31:0] cyc_r [0:3];
reg [31:0] cmplo_r [0:3];
reg [31:0] cmphi_r [0:3];
reg [31:0] lim_r [0:3];
reg [31:0] irqn_r [0:3];
reg [15:0] chcode_r [0:3];
reg [3:0] ovf_r;
reg [3:0] bad_q_r;
reg [7:0] istat_r;
reg [7:0] imask_r;
reg [1:0] last_ch_r;

wire [15:0] code_w [0:3];
wire [3:0] bad_w;
wire [3:0] clr_hit;
wire [3:0] new_w;

// ----------------------------------------------------------------
// per channel checks
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
        wire [63:0] cmp = {cmphi_r[g], cmplo_r[g]};
        wire b_scale = scale_r[g] > `HCEC_SCALE_MAX;
        wire b_cyc = (cyc_r[g] < `HCEC_CYC_MIN) || (cyc_r[g] > `HCEC_CYC_MAX);
        wire b_cmp = ($signed(cmp) < $signed(`HCEC_CMP_MIN))
            || ($signed(cmp) > $signed(`HCEC_CMP_MAX));
        wire b_lim = ($signed(lim_r[g]) < $signed(`HCEC_LIM_MIN))
            || ($signed(lim_r[g]) > $signed(`HCEC_LIM_MAX));
        wire b_irqn = irqn_r[g] > `HCEC_IRQN_MAX;
        reg [3:0] typ;
        always @* begin
            if (ovf_r[g]) begin
                typ = `HCEC_TYP_OVF;
            end else if (b_scale) begin
                typ = `HCEC_TYP_SCALE;
            end else if (b_cyc) begin
                typ = `HCEC_TYP_CYC;
            end else if (b_cmp) begin
                typ = `HCEC_TYP_CMP;
            end else if (b_lim) begin
                typ = `HCEC_TYP_LIM;
            end else if (b_irqn) begin
                typ = `HCEC_TYP_IRQN;
            end else begin
                typ = `HCEC_TYP_NONE;
            end
        end
        wire [31:0] ch_idx = g;
        wire [3:0] ch_nib = ch_idx[3:0];
        // prefix, channel minus one, type
        assign code_w[g] = (typ == `HCEC_TYP_NONE) ? 16'h0000
            : {`HCEC_ERR_PREFIX, ch_nib, typ};
        assign bad_w[g] = b_scale | b_cyc | b_cmp | b_lim | b_irqn;
        assign clr_hit[g] = wr && (addr == g * `HCEC_CH_STRIDE + `HCEC_OFF_CTRL)
            && wdata[`HCEC_CTRL_CLR_BIT];
        assign new_w[g] = (code_w[g] != 16'h0000) && (code_w[g] != chcode_r[g]);
    end
endgenerate

// ----------------------------------------------------------------
// register writes and channel state
// ----------------------------------------------------------------
integer i;
always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        for (i = 0; i < 4; i = i + 1) begin
            ctrl_r[i] <= `HCEC_RST_ZERO;
            scale_r[i] <= `HCEC_RST_ZERO;
            cyc_r[i] <= `HCEC_RST_CYC;
            cmplo_r[i] <= `HCEC_RST_ZERO;
            cmphi_r[i] <= `HCEC_RST_ZERO;
            lim_r[i] <= `HCEC_RST_ZERO;
            irqn_r[i] <= `HCEC_RST_ZERO;
            chcode_r[i] <= 16'h0000;
        end
        ovf_r <= 4'h0;
        bad_q_r <= 4'h0;
        acc_clr <= 4'h0;
        imask_r <= 8'h00;
    end else begin
        for (i = 0; i < 4; i = i + 1) begin
            if (wr && addr == i * `HCEC_CH_STRIDE + `HCEC_OFF_CTRL) begin
                // clear bit is a trigger, never stored
                ctrl_r[i] <= wdata & ~(32'h1 << `HCEC_CTRL_CLR_BIT);
            end
            if (wr && addr == i * `HCEC_CH_STRIDE + `HCEC_OFF_SCALE) begin
                scale_r[i] <= wdata;
            end
            if (wr && addr == i * `HCEC_CH_STRIDE + `HCEC_OFF_CYC) begin
                cyc_r[i] <= wdata;
            end
            if (wr && addr == i * `HCEC_CH_STRIDE + `HCEC_OFF_CMP_LO) begin
                cmplo_r[i] <= wdata;
            end
            if (wr && addr == i * `HCEC_CH_STRIDE + `HCEC_OFF_CMP_HI) begin
                cmphi_r[i] <= wdata;
            end
            if (wr && addr == i * `HCEC_CH_STRIDE + `HCEC_OFF_LIMIT) begin
                lim_r[i] <= wdata;
            end
            if (wr && addr == i * `HCEC_CH_STRIDE + `HCEC_OFF_IRQN) begin
                irqn_r[i] <= wdata;
            end
            chcode_r[i] <= code_w[i];
        end
        // overflow is sticky, a new overflow wins over a clear
        ovf_r <= acc_ovf | (ovf_r & ~clr_hit);
        acc_clr <= clr_hit;
        bad_q_r <= bad_w;
        if (wr && addr == `HCEC_ADDR_IMASK) begin
            imask_r <= wdata[7:0];
        end
    end
end

// ----------------------------------------------------------------
// latest error code
// ----------------------------------------------------------------
reg [1:0] pick;
reg any_new;
integer j;
always @* begin
    pick = 2'd0;
    any_new = 1'b0;
    for (j = 3; j >= 0; j = j - 1) begin
        if (new_w[j]) begin
            pick = j[1:0];
            any_new = 1'b1;
        end
    end
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        err_code <= 16'h0000;
        err_valid <= 1'b0;
        last_ch_r <= 2'd0;
    end else if (any_new) begin
        err_code <= code_w[pick];
        err_valid <= 1'b1;
        last_ch_r <= pick;
    end else if (err_valid && code_w[last_ch_r] == 16'h0000) begin
        err_code <= 16'h0000;
        err_valid <= 1'b0;
    end
end

// ----------------------------------------------------------------
// interrupt status, read clears, set wins
// ----------------------------------------------------------------
wire [7:0] ev = {bad_w & ~bad_q_r, acc_ovf};
wire stat_rd = rd && (addr == `HCEC_ADDR_ISTAT);
wire [7:0] istat_nxt = ev | (stat_rd ? 8'h00 : istat_r);

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        istat_r <= 8'h00;
        irq <= 1'b0;
    end else begin
        istat_r <= istat_nxt;
        irq <= |(istat_nxt & imask_r);
    end
end

// ----------------------------------------------------------------
// read port
// ----------------------------------------------------------------
reg [31:0] rdata_nxt;
integer k;
always @* begin
    rdata_nxt = 32'h0000_0000;
    for (k = 0; k < 4; k = k + 1) begin
        if (addr == k * `HCEC_CH_STRIDE + `HCEC_OFF_CTRL) begin
            rdata_nxt = ctrl_r[k];
        end
        if (addr == k * `HCEC_CH_STRIDE + `HCEC_OFF_SCALE) begin
            rdata_nxt = scale_r[k];
        end
        if (addr == k * `HCEC_CH_STRIDE + `HCEC_OFF_CYC) begin
            rdata_nxt = cyc_r[k];
        end
        if (addr == k * `HCEC_CH_STRIDE + `HCEC_OFF_CMP_LO) begin
            rdata_nxt = cmplo_r[k];
        end
        if (addr == k * `HCEC_CH_STRIDE + `HCEC_OFF_CMP_HI) begin
            rdata_nxt = cmphi_r[k];
        end
        if (addr == k * `HCEC_CH_STRIDE + `HCEC_OFF_LIMIT) begin
            rdata_nxt = lim_r[k];
        end
        if (addr == k * `HCEC_CH_STRIDE + `HCEC_OFF_IRQN) begin
            rdata_nxt = irqn_r[k];
        end
        if (addr == k * `HCEC_CH_STRIDE + `HCEC_OFF_CHERR) begin
            rdata_nxt = {16'h0000, chcode_r[k]};
        end
    end
    case (addr)
        `HCEC_ADDR_LAST: begin
            rdata_nxt = {15'h0000, err_valid, err_code};
        end
        `HCEC_ADDR_ISTAT: begin
            rdata_nxt = {24'h000000, istat_r};
        end
        `HCEC_ADDR_IMASK: begin
            rdata_nxt = {24'h000000, imask_r};
        end
        default: begin
        end
    endcase
end

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        rdata <= 32'h0000_0000;
    end else if (rd) begin
        rdata <= rdata_nxt;
    end else begin
        rdata <= 32'h0000_0000;
    end
end

endmodule // hcec_checker

// ==== test/counter_param_error_checker_bench.sv ====
// self-checking bench of the parameter checker
`timescale 1ns/100ps
module counter_param_error_checker_bench;
    reg clock, nrst, wr, rd;
    reg [6:0] addr;
    reg [31:0] wdata;
    reg [3:0] step;
    wire [31:0] rdata;
    wire [3:0] acc_ovf, acc_clr, full_r;
    wire [15:0] err_code;
    wire err_valid, irq;
    integer n_fail = 0;
    integer n_tests = 0;
    integer i;
    reg [86:0] rows [0:11];
    hcec_checker i_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .acc_ovf(acc_ovf), .acc_clr(acc_clr), .err_code(err_code),
        .err_valid(err_valid), .irq(irq));
    hcec_acc_model i_model (.clock(clock), .nrst(nrst), .step(step), .acc_clr(acc_clr),
        .acc_ovf(acc_ovf), .full_r(full_r));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task idle(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    task wr_reg(input [6:0] a, input [31:0] d);
        begin
            @(posedge clock);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clock);
            wr <= 1'b0;
        end
    endtask
    task rd_chk(input [6:0] a, input [31:0] exp);
        begin
            @(posedge clock);
            addr <= a;
            rd <= 1'b1;
            @(posedge clock);
            rd <= 1'b0;
            #1 chk(rdata, exp);
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #(5000 * 50);
        n_fail = n_fail + 1;
        report_and_stop;
    end
    initial begin
        // addr, bad value, legal value, code
        rows[0] = {7'h01, 32'h0000_8000, 32'h0000_7FFF, 16'hA002};
        rows[1] = {7'h1D, 32'hFFFF_FFFF, 32'h0000_0000, 16'hA012};
        rows[2] = {7'h02, 32'h0000_0001, 32'h0000_003C, 16'hA003};
        rows[3] = {7'h3A, 32'h0000_003D, 32'h0000_0002, 16'hA023};
        rows[4] = {7'h04, 32'h0000_0001, 32'h0000_0000, 16'hA004};
        rows[5] = {7'h04, 32'hFFFF_FFFD, 32'h0000_0000, 16'hA004};
        rows[6] = {7'h05, 32'h0003_0D41, 32'h0003_0D40, 16'hA005};
        rows[7] = {7'h05, 32'hFFFC_F2BF, 32'hFFFC_F2C0, 16'hA005};
        rows[8] = {7'h21, 32'h0003_0D41, 32'h0000_0000, 16'hA015};
        rows[9] = {7'h06, 32'h0000_0020, 32'h0000_001F, 16'hA006};
        rows[10] = {7'h22, 32'h0000_0020, 32'h0000_0000, 16'hA016};
        rows[11] = {7'h55, 32'h0000_8000, 32'h0000_0000, 16'hA032};
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 7'h00;
        wdata = 32'h0;
        step = 4'h0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        for (i = 0; i < 12; i = i + 1) begin
            wr_reg(rows[i][86:80], rows[i][79:48]);
            idle(2);
            chk({15'h0, err_valid, err_code}, {15'h0, 1'b1, rows[i][15:0]});
            rd_chk(rows[i][86:80] / 28 * 28 + 7, {16'h0, rows[i][15:0]});
            rd_chk(7'h70, {15'h0, 1'b1, rows[i][15:0]});
            wr_reg(rows[i][86:80], rows[i][47:16]);
            idle(2);
            rd_chk(7'h70, 32'h0);
        end
        chk({31'h0, irq}, 32'h0); // masked events keep interrupt low
        $display("test rows done");
        wr_reg(7'h01, 32'h0000_8000);
        idle(2);
        chk({15'h0, err_valid, err_code}, 32'h0001_A002);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        #1 chk({15'h0, err_valid, err_code}, 32'h0);
        chk({27'h0, irq, acc_clr}, 32'h0); // outputs idle after reset
        rd_chk(7'h71, 32'h0); // status cleared by reset
        rd_chk(7'h02, 32'h2);
        rd_chk(7'h01, 32'h0);
        wr_reg(7'h7F, 32'hFFFF_FFFF);
        rd_chk(7'h7F, 32'h0); // unmapped place reads zero
        rd_chk(7'h70, 32'h0);
        $display("test reset done");
        wr_reg(7'h72, 32'h0F);
        rd_chk(7'h72, 32'h0F); // mask reads back
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clock);
            step <= 4'h1 << i;
            @(posedge clock);
            step <= 4'h0;
            idle(3);
            chk({31'h0, irq}, 32'h1); // unmasked event raises interrupt
            rd_chk(7'h70, 32'h1_A001 | (i << 4));
            rd_chk(7'h71, 32'h1 << i); // status shows the channel
            idle(2);
            chk({31'h0, irq}, 32'h0); // read cleared the status
            wr_reg(i * 28, 32'h2);
            #1 chk({28'h0, acc_clr}, 32'h1 << i);
            idle(2);
            chk({28'h0, full_r}, 32'h0);
            rd_chk(7'h70, 32'h0);
            rd_chk(i * 28, 32'h0); // clear bit is not stored
        end
        $display("test overflow done");
        report_and_stop;
    end
endmodule // counter_param_error_checker_bench

// ==== test/hcec_acc_model.sv ====
// accumulation model of the four counter channels
`timescale 1ns/100ps
module hcec_acc_model (
    input wire clock,
    input wire nrst,
    input wire [3:0] step,
    input wire [3:0] acc_clr,
    output reg [3:0] acc_ovf,
    output reg [3:0] full_r
);
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc_ovf <= 4'h0;
            full_r <= 4'h0;
        end else begin
            acc_ovf <= step & ~full_r;
            full_r <= (full_r | step) & ~acc_clr;
        end
    end
endmodule // hcec_acc_model

// ==== test/hcec_checker_sva.sv ====
// port assertions of the parameter checker
`timescale 1ns/100ps
module hcec_checker_sva (
    input wire clock,
    input wire nrst,
    input wire [6:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire [3:0] acc_ovf,
    input wire [3:0] acc_clr,
    input wire [15:0] err_code,
    input wire err_valid,
    input wire irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not idle");
    AST_CLR_CH1: assert property (wr && addr == 7'h00 && wdata[1] |=> acc_clr == 4'h1)
        else $error("channel 1 clear missing");
    AST_CLR_CH4: assert property (wr && addr == 7'h54 && wdata[1] |=> acc_clr == 4'h8)
        else $error("channel 4 clear missing");
    AST_OVF_CH1: assert property ($rose(acc_ovf[0]) && err_code == 16'h0 && !wr |-> ##2 err_code == 16'hA001)
        else $error("overflow code wrong");
    AST_SCALE_CH1: assert property (wr && addr == 7'h01 && wdata > 32'h7FFF && err_code == 16'h0
        |-> ##2 err_code == 16'hA002)
        else $error("scale code wrong");
    AST_ENCODE: assert property (err_valid |-> err_code[15:8] == 8'hA0 && err_code[7:4] < 4'h4
        && err_code[3:0] inside {[4'h1:4'h6]})
        else $error("code layout wrong");
    AST_VALID: assert property (err_valid == (err_code != 16'h0))
        else $error("valid flag disagrees");
    AST_HOLD: assert property (err_valid && !$past(wr) && $past(acc_ovf) == 4'h0 |=> err_valid && $stable(err_code))
        else $error("code not held");
    C_OVF: cover property (|acc_ovf);
    C_CLR: cover property (|acc_clr);
    C_IRQ: cover property ($rose(irq));
endmodule // hcec_checker_sva
bind hcec_checker hcec_checker_sva i_sva (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .acc_ovf(acc_ovf), .acc_clr(acc_clr),
    .err_code(err_code), .err_valid(err_valid), .irq(irq));
